/* File: shared/acsh_params.svh */
`ifndef ACSH_PARAMS_SVH
`define ACSH_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define ACSH_OFS_NC_CTRL     8'h00
`define ACSH_OFS_SHARED_WORD 8'h04
`define ACSH_OFS_AXIS_CTRL   8'h08
`define ACSH_OFS_SPEED_SCALE 8'h0c
`define ACSH_OFS_AXIS_MODE   8'h10
`define ACSH_OFS_CONFIG      8'h14
`define ACSH_OFS_TARGET      8'h18
`define ACSH_OFS_STATUS      8'h1c
`define ACSH_OFS_SETPOINT    8'h20
`define ACSH_OFS_FOLLOW_ERR  8'h24

// ==========================================================================
// Axis control word bit positions
`define ACSH_B_POS_REQ     0
`define ACSH_B_HOME_SW     1
`define ACSH_B_CLR_TRAVEL  2
`define ACSH_B_FEED_HOLD   3
`define ACSH_B_DIR_NEG     4
`define ACSH_B_DIR_POS     5
`define ACSH_B_CAM_EN      6
`define ACSH_B_LOOP_EN     7
`define ACSH_B_ROT_CHECK   8
`define ACSH_B_TRACK       9
`define ACSH_B_RAPID       10
`define ACSH_B_SCALE_APPLY 11
`define ACSH_B_SYNC_START  12
`define ACSH_AXIS_CTRL_W   13

// ==========================================================================
// Status bit positions
`define ACSH_S_SERVO_EN    0
`define ACSH_S_TRACK_ACT   1
`define ACSH_S_FAULT       2
`define ACSH_S_HOMED       3

// ==========================================================================
// Other fields and reset values
`define ACSH_B_SYNC_DIS    0
`define ACSH_B_CLR_EDGE    0
`define ACSH_SHARED_W      16
`define ACSH_SCALE_W       8
`define ACSH_POS_W         32
`define ACSH_SCALE_UNITY   8'h64
`define ACSH_RST_AXIS_CTRL 13'h0000
`define ACSH_RST_SCALE     8'h64

`endif

/* File: shared/acsh_pkg.sv */
package acsh_pkg;

	// Operating mode of the axis
	typedef enum logic [1:0]
	{
		ACSH_MODE_JOG,
		ACSH_MODE_INCR,
		ACSH_MODE_HOMING,
		ACSH_MODE_AUTO
	} acsh_mode_t;

	// Position loop state
	typedef enum logic [1:0]
	{
		ACSH_LOOP_HOLD,
		ACSH_LOOP_TRACK,
		ACSH_LOOP_CLOSED
	} acsh_loop_t;

endpackage

/* File: src/acsh_edge_det.sv */
module acsh_edge_det #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         resetn,
	input  wire logic         en,
	input  wire logic [W-1:0] level,
	output logic      [W-1:0] rise
);

	logic [W-1:0] prev_ff;

	// ======================================================================
	// Previous level, advanced only on enabled cycles
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			prev_ff <= '0;
		else if (en)
			prev_ff <= level;
	end

	assign rise = level & ~prev_ff;

endmodule // acsh_edge_det

/* File: src/acsh_axis_ctrl.sv */
`include "acsh_params.svh"

module acsh_axis_ctrl
	import acsh_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	input  wire logic        update_tick,
	input  wire logic        drive_fault,
	input  wire logic        homing_done,
	input  wire logic [31:0] actual_pos,
	output logic             sync_action_suppress,
	output logic      [15:0] sync_word,
	output logic             host_pos_ctrl,
	output logic             home_switch_out,
	output logic             travel_clear,
	output logic             motion_inhibit,
	output logic             jog_neg,
	output logic             jog_pos,
	output logic             start_neg,
	output logic             start_pos,
	output logic             cam_pairs_active,
	output logic             servo_enable,
	output logic             rotation_monitor_on,
	output logic             track_actual_active,
	output logic             rapid_active,
	output logic      [7:0]  speed_scale_out,
	output logic             gantry_sync_start,
	output logic             axis_homed,
	output logic      [31:0] setpoint
);

	// ======================================================================
	// Bus slave state
	logic        dph_valid_ff;
	logic        dph_write_ff;
	logic [7:0]  dph_addr_ff;
	logic        hreadyout_ff;
	logic [31:0] hrdata_ff;
	logic        wr_en;
	logic        rd_done;
	logic [31:0] rd_mux;

	// Software registers
	logic                        sync_dis_ff;
	logic [15:0]                 shared_word_ff;
	logic [12:0]                 axis_ctrl_ff;
	logic [7:0]                  scale_ff;
	acsh_mode_t                  mode_ff;
	logic                        clr_edge_ff;
	logic [31:0]                 target_ff;
	logic                        target_wr_ff;
	logic                        fault_ff;

	// Sampled copies
	logic        smp_sync_dis_ff;
	logic [15:0] smp_word_ff;
	logic [12:0] smp_ctrl_ff;
	logic [7:0]  smp_scale_ff;
	acsh_mode_t  smp_mode_ff;
	logic        apply_ff;
	logic        act;
	logic [3:0]  rise;

	// Loop and outputs
	acsh_loop_t  loop_ff;
	acsh_loop_t  nxt_loop;
	logic [31:0] setpoint_ff;
	logic [31:0] follow_err_ff;
	logic        homed_ff;
	logic        sync_sup_ff;
	logic [15:0] sync_word_ff;
	logic        pos_ctrl_ff;
	logic        home_sw_ff;
	logic        clr_ff;
	logic        inhibit_ff;
	logic        jog_neg_ff;
	logic        jog_pos_ff;
	logic        start_neg_ff;
	logic        start_pos_ff;
	logic        cam_ff;
	logic        rot_mon_ff;
	logic        rapid_ff;
	logic [7:0]  scale_out_ff;
	logic        gantry_ff;
	logic        step_mode;
	logic        servo_en_ff;
	logic        trk_act_ff;

	// ======================================================================
	// AHB-Lite slave: writes zero-wait, reads one wait state
	assign wr_en   = ce && dph_valid_ff && dph_write_ff && hready;
	assign rd_done = dph_valid_ff && !dph_write_ff && !hreadyout_ff;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			dph_valid_ff <= 1'b0;
			dph_write_ff <= 1'b0;
			dph_addr_ff  <= 8'h00;
			hreadyout_ff <= 1'b1;
			hrdata_ff    <= 32'h0000_0000;
		end
		else if (ce)
		begin
			if (rd_done)
			begin
				hrdata_ff    <= rd_mux;
				hreadyout_ff <= 1'b1;
				dph_valid_ff <= 1'b0;
			end
			else if (hready)
			begin
				dph_valid_ff <= hsel && htrans[1];
				dph_write_ff <= hwrite;
				dph_addr_ff  <= haddr;
				if (hsel && htrans[1] && !hwrite)
					hreadyout_ff <= 1'b0;
			end
		end
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (dph_addr_ff)
			`ACSH_OFS_NC_CTRL:     rd_mux[`ACSH_B_SYNC_DIS] = sync_dis_ff;
			`ACSH_OFS_SHARED_WORD: rd_mux[15:0] = shared_word_ff;
			`ACSH_OFS_AXIS_CTRL:   rd_mux[12:0] = axis_ctrl_ff;
			`ACSH_OFS_SPEED_SCALE: rd_mux[7:0] = scale_ff;
			`ACSH_OFS_AXIS_MODE:   rd_mux[1:0] = mode_ff;
			`ACSH_OFS_CONFIG:      rd_mux[`ACSH_B_CLR_EDGE] = clr_edge_ff;
			`ACSH_OFS_TARGET:      rd_mux = target_ff;
			`ACSH_OFS_STATUS:
			begin
				rd_mux[`ACSH_S_SERVO_EN]  = servo_enable;
				rd_mux[`ACSH_S_TRACK_ACT] = track_actual_active;
				rd_mux[`ACSH_S_FAULT]     = fault_ff;
				rd_mux[`ACSH_S_HOMED]     = homed_ff;
			end
			`ACSH_OFS_SETPOINT:    rd_mux = setpoint_ff;
			`ACSH_OFS_FOLLOW_ERR:  rd_mux = follow_err_ff;
			default:               rd_mux = 32'h0000_0000;
		endcase
	end

	// ======================================================================
	// Software registers
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			sync_dis_ff    <= 1'b0;
			shared_word_ff <= 16'h0000;
			axis_ctrl_ff   <= `ACSH_RST_AXIS_CTRL;
			scale_ff       <= `ACSH_RST_SCALE;
			mode_ff        <= ACSH_MODE_JOG;
			clr_edge_ff    <= 1'b0;
			target_ff      <= 32'h0000_0000;
			target_wr_ff   <= 1'b0;
		end
		else if (ce)
		begin
			target_wr_ff <= 1'b0;
			if (wr_en)
			begin
				unique case (dph_addr_ff)
					`ACSH_OFS_NC_CTRL:
						sync_dis_ff <= hwdata[`ACSH_B_SYNC_DIS];
					`ACSH_OFS_SHARED_WORD: shared_word_ff <= hwdata[15:0];
					`ACSH_OFS_AXIS_CTRL:   axis_ctrl_ff <= hwdata[12:0];
					`ACSH_OFS_SPEED_SCALE: scale_ff <= hwdata[7:0];
					`ACSH_OFS_AXIS_MODE:
						mode_ff <= acsh_mode_t'(hwdata[1:0]);
					`ACSH_OFS_CONFIG:
						clr_edge_ff <= hwdata[`ACSH_B_CLR_EDGE];
					`ACSH_OFS_TARGET:
					begin
						target_ff    <= hwdata;
						target_wr_ff <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// Fault latch, set wins over the clear by writing status
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			fault_ff <= 1'b0;
		else if (ce)
		begin
			if (drive_fault)
				fault_ff <= 1'b1;
			else if (wr_en && dph_addr_ff == `ACSH_OFS_STATUS
				&& hwdata[`ACSH_S_FAULT])
				fault_ff <= 1'b0;
		end
	end

	// ======================================================================
	// Sampling once per cyclic exchange
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			smp_sync_dis_ff <= 1'b0;
			smp_word_ff     <= 16'h0000;
			smp_ctrl_ff     <= `ACSH_RST_AXIS_CTRL;
			smp_scale_ff    <= `ACSH_RST_SCALE;
			smp_mode_ff     <= ACSH_MODE_JOG;
			apply_ff        <= 1'b0;
		end
		else if (ce)
		begin
			apply_ff <= update_tick;
			if (update_tick)
			begin
				smp_sync_dis_ff <= sync_dis_ff;
				smp_word_ff     <= shared_word_ff;
				smp_ctrl_ff     <= axis_ctrl_ff;
				smp_scale_ff    <= scale_ff;
				smp_mode_ff     <= mode_ff;
			end
		end
	end

	assign act = ce && apply_ff;
	assign step_mode = smp_mode_ff == ACSH_MODE_INCR
		|| smp_mode_ff == ACSH_MODE_HOMING;

	acsh_edge_det #(
		.W(4)
	) acsh_edge_det_inst (
		.mclk   (mclk),
		.resetn (resetn),
		.en     (act),
		.level  ({smp_ctrl_ff[`ACSH_B_SYNC_START],
			smp_ctrl_ff[`ACSH_B_DIR_POS],
			smp_ctrl_ff[`ACSH_B_DIR_NEG],
			smp_ctrl_ff[`ACSH_B_CLR_TRAVEL]}),
		.rise   (rise)
	);

	// ======================================================================
	// Control outputs, refreshed on the cycle after sampling
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			sync_sup_ff  <= 1'b0;
			sync_word_ff <= 16'h0000;
			pos_ctrl_ff  <= 1'b0;
			home_sw_ff   <= 1'b0;
			clr_ff       <= 1'b0;
			inhibit_ff   <= 1'b0;
			jog_neg_ff   <= 1'b0;
			jog_pos_ff   <= 1'b0;
			start_neg_ff <= 1'b0;
			start_pos_ff <= 1'b0;
			cam_ff       <= 1'b0;
			rot_mon_ff   <= 1'b0;
			rapid_ff     <= 1'b0;
			scale_out_ff <= `ACSH_SCALE_UNITY;
			gantry_ff    <= 1'b0;
		end
		else if (act)
		begin
			sync_sup_ff  <= smp_sync_dis_ff;
			sync_word_ff <= smp_word_ff;
			pos_ctrl_ff  <= smp_ctrl_ff[`ACSH_B_POS_REQ];
			home_sw_ff   <= smp_ctrl_ff[`ACSH_B_HOME_SW];
			clr_ff       <= clr_edge_ff ? rise[0]
				: smp_ctrl_ff[`ACSH_B_CLR_TRAVEL];
			inhibit_ff   <= smp_ctrl_ff[`ACSH_B_FEED_HOLD];
			jog_neg_ff   <= smp_ctrl_ff[`ACSH_B_DIR_NEG]
				&& smp_mode_ff == ACSH_MODE_JOG;
			jog_pos_ff   <= smp_ctrl_ff[`ACSH_B_DIR_POS]
				&& smp_mode_ff == ACSH_MODE_JOG;
			start_neg_ff <= rise[1] && step_mode;
			start_pos_ff <= rise[2] && step_mode;
			cam_ff       <= smp_ctrl_ff[`ACSH_B_CAM_EN];
			rot_mon_ff   <= smp_ctrl_ff[`ACSH_B_ROT_CHECK];
			rapid_ff     <= smp_ctrl_ff[`ACSH_B_RAPID]
				&& (smp_mode_ff == ACSH_MODE_JOG
				|| smp_mode_ff == ACSH_MODE_INCR);
			scale_out_ff <= smp_ctrl_ff[`ACSH_B_SCALE_APPLY]
				? smp_scale_ff : `ACSH_SCALE_UNITY;
			gantry_ff    <= rise[3];
		end
		else if (ce)
		begin
			// Start pulses last one cycle
			start_neg_ff <= 1'b0;
			start_pos_ff <= 1'b0;
			gantry_ff    <= 1'b0;
			if (clr_edge_ff)
				clr_ff <= 1'b0;
		end
	end

	// ======================================================================
	// Position loop
	always_comb
	begin
		if (smp_ctrl_ff[`ACSH_B_LOOP_EN] && !fault_ff)
			nxt_loop = ACSH_LOOP_CLOSED;
		else if (smp_ctrl_ff[`ACSH_B_TRACK])
			nxt_loop = ACSH_LOOP_TRACK;
		else
			nxt_loop = ACSH_LOOP_HOLD;
	end

	// Loop state and its two status flags, all registered together
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			loop_ff     <= ACSH_LOOP_HOLD;
			servo_en_ff <= 1'b0;
			trk_act_ff  <= 1'b0;
		end
		else if (ce)
		begin
			loop_ff     <= nxt_loop;
			servo_en_ff <= nxt_loop == ACSH_LOOP_CLOSED;
			trk_act_ff  <= nxt_loop == ACSH_LOOP_TRACK;
		end
	end

	// Setpoint tracks actual only while open and tracking
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			setpoint_ff <= 32'h0000_0000;
		else if (ce)
		begin
			unique case (loop_ff)
				ACSH_LOOP_TRACK:  setpoint_ff <= actual_pos;
				ACSH_LOOP_HOLD:   setpoint_ff <= setpoint_ff;
				ACSH_LOOP_CLOSED:
					if (target_wr_ff)
						setpoint_ff <= target_ff;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			follow_err_ff <= 32'h0000_0000;
		else if (ce)
			follow_err_ff <= setpoint_ff - actual_pos;
	end

	// Homed state survives track mode changes
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			homed_ff <= 1'b0;
		else if (ce && homing_done)
			homed_ff <= 1'b1;
	end

	// ======================================================================
	// Output wiring
	assign hreadyout            = hreadyout_ff;
	assign hrdata               = hrdata_ff;
	assign hresp                = 1'b0;
	assign sync_action_suppress = sync_sup_ff;
	assign sync_word            = sync_word_ff;
	assign host_pos_ctrl        = pos_ctrl_ff;
	assign home_switch_out      = home_sw_ff;
	assign travel_clear         = clr_ff;
	assign motion_inhibit       = inhibit_ff;
	assign jog_neg              = jog_neg_ff;
	assign jog_pos              = jog_pos_ff;
	assign start_neg            = start_neg_ff;
	assign start_pos            = start_pos_ff;
	assign cam_pairs_active     = cam_ff;
	assign servo_enable         = servo_en_ff;
	assign rotation_monitor_on  = rot_mon_ff;
	assign track_actual_active  = trk_act_ff;
	assign rapid_active         = rapid_ff;
	assign speed_scale_out      = scale_out_ff;
	assign gantry_sync_start    = gantry_ff;
	assign axis_homed           = homed_ff;
	assign setpoint             = setpoint_ff;

	// ======================================================================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_applied;
		act;
	endsequence

	sequence s_open_track;
		ce && loop_ff == ACSH_LOOP_TRACK;
	endsequence

	a_sync_disable_out: assert property (s_applied |=>
		sync_action_suppress == $past(smp_sync_dis_ff))
		else $error("sync action suppress mismatch");
	a_shared_word_out: assert property (s_applied |=>
		sync_word == $past(smp_word_ff))
		else $error("shared word mismatch");
	a_feed_hold_out: assert property (s_applied |=>
		motion_inhibit == $past(smp_ctrl_ff[`ACSH_B_FEED_HOLD]))
		else $error("feed hold not applied");
	a_jog_neg_mode: assert property (s_applied |=> jog_neg ==
		($past(smp_ctrl_ff[`ACSH_B_DIR_NEG])
		&& $past(smp_mode_ff) == ACSH_MODE_JOG))
		else $error("jog output outside jog mode");
	a_start_pos_pulse: assert property (start_pos && ce |=>
		!start_pos)
		else $error("start pulse longer than one cycle");
	a_fault_opens_loop: assert property (ce && fault_ff |=>
		!servo_enable)
		else $error("servo enabled during fault");
	a_track_follows: assert property (s_open_track |=>
		setpoint == $past(actual_pos))
		else $error("setpoint not tracking actual");
	a_hold_setpoint: assert property
		(ce && loop_ff == ACSH_LOOP_HOLD |=> $stable(setpoint))
		else $error("setpoint moved while holding");
	a_track_ignored: assert property
		(ce && smp_ctrl_ff[`ACSH_B_LOOP_EN] && !fault_ff
		&& smp_ctrl_ff[`ACSH_B_TRACK] |=> servo_enable
		&& !track_actual_active)
		else $error("track flag while servo enabled");
	a_sample_act: assert property (ce && update_tick
		|=> apply_ff && smp_ctrl_ff == $past(axis_ctrl_ff))
		else $error("inputs not sampled on tick");

endmodule // acsh_axis_ctrl

/* File: sim/acsh_host_model.sv */
module acsh_host_model
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        drift,
	output logic             update_tick,
	output logic      [31:0] actual_pos
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] tick_cnt_ff;

	// ====================
	// Cyclic exchange, one tick in twelve cycles
	always_ff @(posedge mclk)
	begin
		if (!resetn || tick_cnt_ff == 4'hb)
			tick_cnt_ff <= 4'h0;
		else
			tick_cnt_ff <= tick_cnt_ff + 4'h1;
	end

	always_ff @(posedge mclk)
	begin
		update_tick <= resetn && (tick_cnt_ff == 4'ha);
	end

	// ====================
	// Measured position, moved by hand while drift is high
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			actual_pos <= 32'h00000100;
		else if (drift)
			actual_pos <= actual_pos + 32'h3;
	end
endmodule // acsh_host_model

/* File: sim/axis_control_signal_handler_bench.sv */
`include "acsh_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	err_total++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
	end end

module axis_control_signal_handler_bench
	import acsh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk, resetn, hwrite, hreadyout, hresp, update_tick;
	logic        drive_fault, homing_done, drift, ce;
	logic [7:0]  haddr, speed_scale_out;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata, actual_pos, setpoint, rdv, sp;
	logic [15:0] sync_word;
	logic        sync_action_suppress, host_pos_ctrl, home_switch_out;
	logic        travel_clear, motion_inhibit, jog_neg, jog_pos;
	logic        start_neg, start_pos, cam_pairs_active, servo_enable;
	logic        rotation_monitor_on, track_actual_active, rapid_active;
	logic        gantry_sync_start, axis_homed;
	int          err_total, total_checks;

	acsh_axis_ctrl acsh_axis_ctrl_inst (.mclk(mclk), .resetn(resetn),
		.ce(ce), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .update_tick(update_tick),
		.drive_fault(drive_fault), .homing_done(homing_done),
		.actual_pos(actual_pos),
		.sync_action_suppress(sync_action_suppress),
		.sync_word(sync_word), .host_pos_ctrl(host_pos_ctrl),
		.home_switch_out(home_switch_out), .travel_clear(travel_clear),
		.motion_inhibit(motion_inhibit), .jog_neg(jog_neg),
		.jog_pos(jog_pos), .start_neg(start_neg), .start_pos(start_pos),
		.cam_pairs_active(cam_pairs_active), .servo_enable(servo_enable),
		.rotation_monitor_on(rotation_monitor_on),
		.track_actual_active(track_actual_active),
		.rapid_active(rapid_active), .speed_scale_out(speed_scale_out),
		.gantry_sync_start(gantry_sync_start), .axis_homed(axis_homed),
		.setpoint(setpoint));

	acsh_host_model acsh_host_model_inst (.mclk(mclk), .resetn(resetn),
		.drift(drift), .update_tick(update_tick),
		.actual_pos(actual_pos));

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// ====================
	// Helpers
	task print_verdict;
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task tmo;
		err_total++;
		print_verdict();
	endtask

	task settle(input int k);
		repeat (k) @(posedge mclk);
	endtask

	function automatic logic [31:0] bitv(input int b);
		return 32'h1 << b;
	endfunction

	task wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20)
			tmo();
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= 1'b1;
		htrans <= 2'b10;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		haddr <= a;
		hwrite <= 1'b0;
		htrans <= 2'b10;
		wait_rdy();
		htrans <= 2'b00;
		wait_rdy();
		d = hrdata;
	endtask

	// Lands on the second edge after a taken tick
	task sync;
		int n;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (update_tick !== 1'b1 && n < 40);
		if (n >= 40)
			tmo();
		settle(2);
	endtask

	// ====================
	// Scenarios
	task t_reset;
		`CHK(hreadyout, 1'b1)
		`CHK(hresp, 1'b0)
		`CHK(speed_scale_out, 8'h64)
		`CHK(servo_enable, 1'b0)
		rd(`ACSH_OFS_SPEED_SCALE, rdv);
		`CHK(rdv, 32'h64)
		wr(8'h40, 32'hffffffff);
		rd(8'h40, rdv);
		`CHK(rdv, 32'h0)
	endtask

	task t_nc;
		sync();
		wr(`ACSH_OFS_NC_CTRL, 32'h1);
		wr(`ACSH_OFS_SHARED_WORD, 32'h0000beef);
		`CHK(sync_action_suppress, 1'b0)
		sync();
		`CHK(sync_action_suppress, 1'b1)
		`CHK(sync_word, 16'hbeef)
	endtask

	task t_levels;
		int b[5] = '{`ACSH_B_POS_REQ, `ACSH_B_HOME_SW, `ACSH_B_FEED_HOLD,
			`ACSH_B_CAM_EN, `ACSH_B_ROT_CHECK};
		for (int i = 0; i < 6; i++)
		begin
			wr(`ACSH_OFS_AXIS_CTRL, (i < 5) ? bitv(b[i]) : 32'h0);
			sync();
			`CHK({host_pos_ctrl, home_switch_out, motion_inhibit,
				cam_pairs_active, rotation_monitor_on},
				5'b10000 >> i)
		end
	endtask

	task t_modes;
		logic [31:0] c;
		c = bitv(`ACSH_B_DIR_NEG) | bitv(`ACSH_B_DIR_POS)
			| bitv(`ACSH_B_RAPID) | bitv(`ACSH_B_SYNC_START);
		for (int m = 0; m < 4; m++)
		begin
			wr(`ACSH_OFS_AXIS_MODE, m);
			wr(`ACSH_OFS_AXIS_CTRL, c);
			sync();
			`CHK({jog_neg, jog_pos}, {2{m == 0}})
			`CHK({start_neg, start_pos}, {2{m == 1 || m == 2}})
			`CHK(rapid_active, m < 2)
			`CHK(gantry_sync_start, 1'b1)
			@(posedge mclk);
			`CHK({start_neg, start_pos, gantry_sync_start}, 3'b000)
			wr(`ACSH_OFS_AXIS_CTRL, 32'h0);
			sync();
		end
		wr(`ACSH_OFS_AXIS_MODE, 32'h0);
	endtask

	task t_scale_clear;
		wr(`ACSH_OFS_SPEED_SCALE, 32'h20);
		sync();
		`CHK(speed_scale_out, 8'h64)
		wr(`ACSH_OFS_AXIS_CTRL, bitv(`ACSH_B_SCALE_APPLY));
		sync();
		`CHK(speed_scale_out, 8'h20)
		for (int e = 0; e < 2; e++)
		begin
			wr(`ACSH_OFS_CONFIG, e);
			wr(`ACSH_OFS_AXIS_CTRL, bitv(`ACSH_B_CLR_TRAVEL));
			sync();
			`CHK(travel_clear, 1'b1)
			settle(2);
			`CHK(travel_clear, e == 0)
			wr(`ACSH_OFS_AXIS_CTRL, 32'h0);
			sync();
			`CHK(travel_clear, 1'b0)
		end
	endtask

	task t_loop;
		// Loop enable held true, as a stepper axis needs
		wr(`ACSH_OFS_AXIS_CTRL, bitv(`ACSH_B_LOOP_EN));
		sync();
		settle(2);
		`CHK(servo_enable, 1'b1)
		wr(`ACSH_OFS_TARGET, 32'h0000_1234);
		settle(2);
		`CHK(setpoint, 32'h0000_1234)
		drive_fault <= 1'b1;
		settle(2);
		drive_fault <= 1'b0;
		settle(3);
		`CHK(servo_enable, 1'b0)
		rd(`ACSH_OFS_STATUS, rdv);
		`CHK(rdv[`ACSH_S_FAULT], 1'b1)
		wr(`ACSH_OFS_STATUS, bitv(`ACSH_S_FAULT));
		settle(3);
		`CHK(servo_enable, 1'b1)
		wr(`ACSH_OFS_AXIS_CTRL,
			bitv(`ACSH_B_LOOP_EN) | bitv(`ACSH_B_TRACK));
		sync();
		settle(2);
		`CHK(track_actual_active, 1'b0)
		homing_done <= 1'b1;
		@(posedge mclk);
		homing_done <= 1'b0;
		drift <= 1'b1;
		wr(`ACSH_OFS_AXIS_CTRL, bitv(`ACSH_B_TRACK));
		sync();
		settle(2);
		`CHK({servo_enable, track_actual_active}, 2'b01)
		`CHK(setpoint, actual_pos - 32'h3)
		// Clock enable low freezes tracking while the axis still drifts
		ce <= 1'b0;
		@(posedge mclk);
		sp = setpoint;
		settle(3);
		`CHK(setpoint, sp)
		ce <= 1'b1;
		wr(`ACSH_OFS_AXIS_CTRL, 32'h0);
		sync();
		settle(2);
		sp = setpoint;
		settle(4);
		`CHK(setpoint, sp)
		`CHK(track_actual_active, 1'b0)
		`CHK(axis_homed, 1'b1)
		drift <= 1'b0;
		settle(2);
		rd(`ACSH_OFS_FOLLOW_ERR, rdv);
		`CHK(rdv, sp - actual_pos)
	endtask

	// ====================
	// Main sequence
	initial
	begin
		err_total = 0;
		total_checks = 0;
		resetn = 1'b0;
		haddr = 8'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		drive_fault = 1'b0;
		homing_done = 1'b0;
		drift = 1'b0;
		ce = 1'b1;
		settle(6);
		resetn <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_nc();
		t_levels();
		t_modes();
		t_scale_clear();
		t_loop();
		print_verdict();
	end
endmodule // axis_control_signal_handler_bench
